//--- verilog/iosv_pkg.sv
// package: constants for the i/o space and vector control block
package iosv_pkg;
    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [5:0]  IO_MCU_CONTROL   = 6'h35;
    localparam logic [7:0]  DS_MCU_CONTROL   = 8'h55;
    localparam logic [7:0]  IO_DATA_OFFSET   = 8'h20;
    localparam logic [5:0]  IO_BIT_LIMIT     = 6'h1F;
    localparam logic [7:0]  IO_WINDOW_TOP    = 8'h3F;
    // ------------------------------------------------------------
    // mcu control register fields
    // ------------------------------------------------------------
    localparam int          BIT_JTD          = 7;
    localparam int          BIT_BROWNOUT_SLEEP_OFF         = 6;
    localparam int          BIT_BROWNOUT_SLEEP_OFF_ENABLE        = 5;
    localparam int          BIT_PUD          = 4;
    localparam int          BIT_VSEL         = 1;
    localparam int          BIT_VCE          = 0;
    localparam logic [7:0]  MCU_RESET        = 8'h00;
    localparam logic [7:0]  MCU_WRITE_MASK   = 8'h93;
    // ------------------------------------------------------------
    // cycle counts
    // ------------------------------------------------------------
    localparam logic [2:0]  RD_STALL_CYC     = 3'h4;
    localparam logic [2:0]  WR_STALL_CYC     = 3'h2;
    localparam logic [2:0]  VCE_WINDOW_CYC   = 3'h4;
    localparam int          EE_WRITE_CYC     = 4000;
    // ------------------------------------------------------------
    // vector addresses (words)
    // ------------------------------------------------------------
    localparam logic [15:0] APP_RESET_VEC    = 16'h0000;
    localparam logic [15:0] VEC_SPACING      = 16'h0002;
    localparam logic [15:0] BOOT_START_DEF   = 16'h3800;
    // io operation codes
    typedef enum logic [2:0] {
        IOSV_OP_NONE  = 3'b000,
        IOSV_OP_READ  = 3'b001,
        IOSV_OP_WRITE = 3'b010,
        IOSV_OP_SETB  = 3'b011,
        IOSV_OP_CLRB  = 3'b100,
        IOSV_OP_TSTB  = 3'b101
    } iosv_op_t;
endpackage

//--- verilog/iosv_ee_timer.sv
// module: eeprom stall and self-timed write engine
`timescale 1ns/100ps
module iosv_ee_timer #(
    parameter int WRITE_CYC = iosv_pkg::EE_WRITE_CYC
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic rd_req,
    input  wire logic wr_req,
    output logic      stall,
    output logic      busy
);
    // ------------------------------------------------------------
    // stall counter
    // ------------------------------------------------------------
    logic [2:0]  stall_cnt;
    logic [31:0] wr_cnt;
    logic        start_wr;

    assign start_wr = wr_req && !busy;
    assign stall    = (stall_cnt != 3'h0);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stall_cnt <= 3'h0;
        end else if (rd_req && !stall) begin
            stall_cnt <= iosv_pkg::RD_STALL_CYC;
        end else if (start_wr && !stall) begin
            stall_cnt <= iosv_pkg::WR_STALL_CYC;
        end else if (stall) begin
            stall_cnt <= stall_cnt - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // write timer, survives reset
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (start_wr && !stall) begin
            wr_cnt <= 32'(WRITE_CYC);
        end else if (wr_cnt != 32'h0) begin
            wr_cnt <= wr_cnt - 32'h1;
        end else begin
            wr_cnt <= 32'h0;
        end
    end
    assign busy = (wr_cnt != 32'h0);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_rd_stall;
        @(posedge clk) disable iff (!rst_b)
        (rd_req && !stall) |=> stall [*4] ##1 !stall;
    endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("read stall not 4");
    property p_wr_stall;
        @(posedge clk) disable iff (!rst_b)
        (start_wr && !stall && !rd_req) |=> stall [*2] ##1 !stall;
    endproperty
    a_wr_stall: assert property (p_wr_stall) else $error("write stall not 2");
    property p_bg_write;
        @(posedge clk) disable iff (!rst_b)
        (start_wr && !stall && !rd_req) |=> ##2 (busy && !stall);
    endproperty
    a_bg_write: assert property (p_bg_write) else $error("write not background");
    c_rd: cover property (@(posedge clk) rd_req && !stall);
    c_wr: cover property (@(posedge clk) start_wr && !stall);
endmodule

//--- verilog/iosv_top.sv
// module: i/o space mapping, eeprom stalls and vector base control
`timescale 1ns/100ps
// Functional notes
// - eeprom read stalls the cpu four cycles
// - eeprom write stalls the cpu two cycles
// - write busy flag readable for polling
// - write continues in power-down; clock request held meanwhile
// - reset does not abort an ongoing eeprom write
// - all io registers reachable by load and store
// - io 0x00-0x1f support bit set, clear and test
// - in/out use six-bit io address
// - data-space address is io address plus 0x20
// - vector table location set by control register bit
// - fuse off, select set: reset 0x0000, vectors boot plus two
// - fuse on, select clear: reset boot, vectors at 0x0002
// - fuse on, select set: reset boot, vectors boot plus two
// - control register bits, 6 and 5 read only, follow brownout inputs, rest reset zero
// - select zero vectors at flash start, one at boot
// - select changes only within four cycles of enable
// - interrupts blocked during change sequence, flag untouched
module iosv_top #(
    parameter logic [15:0] BOOT_START = iosv_pkg::BOOT_START_DEF,
    parameter int          WRITE_CYC  = iosv_pkg::EE_WRITE_CYC
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    input  wire logic [2:0]  IO_OP,
    input  wire logic        IO_DATA_SPACE,
    input  wire logic [7:0]  IO_ADDR,
    input  wire logic [2:0]  IO_BIT,
    input  wire logic [7:0]  IO_WDATA,
    output logic [7:0]       IO_RDATA,
    output logic             IO_HIT,
    output logic             IO_SKIP,
    output logic [5:0]       PERIPH_ADDR,
    output logic             PERIPH_RD,
    output logic             PERIPH_WR,
    output logic [7:0]       PERIPH_WDATA,
    output logic [7:0]       PERIPH_WMASK,
    input  wire logic [7:0]  PERIPH_RDATA,
    input  wire logic        EE_READ,
    input  wire logic        EE_WRITE,
    output logic             CPU_STALL,
    output logic             EE_WRITE_BUSY,
    input  wire logic        SLEEP_POWERDOWN,
    output logic             CLOCK_KEEP,
    input  wire logic        BOOT_RESET_FUSE,
    input  wire logic        BROWNOUT_SLEEP_OFF,
    input  wire logic        BROWNOUT_SLEEP_OFF_ENABLE,
    input  wire logic        INSTR_DONE,
    output logic [15:0]      RESET_VECTOR,
    output logic [15:0]      VECTOR_BASE,
    output logic             IRQ_BLOCK,
    output logic             JTAG_PORT_DISABLE,
    output logic             GLOBAL_PULLUP_DISABLE
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic [7:0] io_full;
    logic       in_window;
    logic [5:0] io_addr;
    logic       bit_ok;
    logic       bit_op;
    logic       is_read;
    logic       is_write;
    logic       mcu_sel;
    logic [7:0] bit_mask;
    logic [7:0] mcu_control_register;
    logic [7:0] mcu_read;
    logic [7:0] cur_rdata;
    iosv_pkg::iosv_op_t op;

    assign op        = iosv_pkg::iosv_op_t'(IO_OP);
    assign io_full   = IO_DATA_SPACE ? (IO_ADDR - iosv_pkg::IO_DATA_OFFSET)
                                     : IO_ADDR;
    assign in_window = IO_DATA_SPACE ? (IO_ADDR >= iosv_pkg::IO_DATA_OFFSET &&
                       io_full <= iosv_pkg::IO_WINDOW_TOP)
                                     : (IO_ADDR <= iosv_pkg::IO_WINDOW_TOP);
    assign io_addr   = io_full[5:0];
    assign bit_op    = (op == iosv_pkg::IOSV_OP_SETB) || (op == iosv_pkg::IOSV_OP_CLRB) ||
                       (op == iosv_pkg::IOSV_OP_TSTB);
    assign bit_ok    = !IO_DATA_SPACE && (io_addr <= iosv_pkg::IO_BIT_LIMIT);
    assign is_read   = in_window && ((op == iosv_pkg::IOSV_OP_READ) ||
                       (bit_op && bit_ok));
    assign is_write  = in_window && ((op == iosv_pkg::IOSV_OP_WRITE) ||
                       (bit_ok && (op == iosv_pkg::IOSV_OP_SETB ||
                                   op == iosv_pkg::IOSV_OP_CLRB)));
    assign mcu_sel   = (io_addr == iosv_pkg::IO_MCU_CONTROL);
    assign bit_mask  = 8'h01 << IO_BIT;

    // ------------------------------------------------------------
    // peripheral strobes
    // ------------------------------------------------------------
    logic [7:0] wr_value;
    logic [7:0] wr_mask;
    assign wr_value = (op == iosv_pkg::IOSV_OP_SETB) ? 8'hFF :
                      (op == iosv_pkg::IOSV_OP_CLRB) ? 8'h00 : IO_WDATA;
    assign wr_mask  = bit_op ? bit_mask : 8'hFF;
    assign PERIPH_ADDR  = io_addr;
    assign PERIPH_RD    = is_read && !mcu_sel && !CPU_STALL;
    assign PERIPH_WR    = is_write && !mcu_sel && !CPU_STALL;
    assign PERIPH_WDATA = wr_value;
    assign PERIPH_WMASK = wr_mask;

    // ------------------------------------------------------------
    // mcu control register and vector change sequence
    // ------------------------------------------------------------
    logic       mcu_wr;
    logic [7:0] merged;
    logic [2:0] vce_cnt;
    logic       vce_open;
    logic       sel_written;
    logic       blk_tail;

    assign mcu_wr   = is_write && mcu_sel && !CPU_STALL;
    assign merged   = (mcu_control_register & ~wr_mask) | (wr_value & wr_mask);
    assign vce_open = (vce_cnt != 3'h0);
    assign sel_written = mcu_wr && vce_open && !merged[iosv_pkg::BIT_VCE];

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            mcu_control_register <= iosv_pkg::MCU_RESET;
        end else if (mcu_wr) begin
            mcu_control_register[iosv_pkg::BIT_JTD] <= merged[iosv_pkg::BIT_JTD];
            mcu_control_register[iosv_pkg::BIT_PUD] <= merged[iosv_pkg::BIT_PUD];
            mcu_control_register[iosv_pkg::BIT_VCE] <= 1'b0;
            if (sel_written) begin
                mcu_control_register[iosv_pkg::BIT_VSEL] <= merged[iosv_pkg::BIT_VSEL];
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            vce_cnt  <= 3'h0;
            blk_tail <= 1'b0;
        end else if (mcu_wr && merged[iosv_pkg::BIT_VCE]) begin
            vce_cnt  <= iosv_pkg::VCE_WINDOW_CYC;
            blk_tail <= 1'b0;
        end else if (sel_written) begin
            vce_cnt  <= 3'h0;
            blk_tail <= 1'b1;
        end else begin
            if (vce_open) begin
                vce_cnt <= vce_cnt - 3'h1;
            end
            if (INSTR_DONE) begin
                blk_tail <= 1'b0;
            end
        end
    end

    assign IRQ_BLOCK = vce_open || blk_tail ||
                       (mcu_wr && merged[iosv_pkg::BIT_VCE]);

    assign mcu_read = {mcu_control_register[iosv_pkg::BIT_JTD],
                       BROWNOUT_SLEEP_OFF, BROWNOUT_SLEEP_OFF_ENABLE,
                       mcu_control_register[iosv_pkg::BIT_PUD],
                       2'b00, mcu_control_register[1], vce_open};
    assign cur_rdata = mcu_sel ? mcu_read : PERIPH_RDATA;

    // ------------------------------------------------------------
    // read data and skip
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            IO_RDATA <= 8'h00;
            IO_HIT   <= 1'b0;
            IO_SKIP  <= 1'b0;
        end else begin
            IO_HIT   <= (is_read || is_write) && !CPU_STALL;
            IO_RDATA <= is_read ? cur_rdata : 8'h00;
            IO_SKIP  <= (op == iosv_pkg::IOSV_OP_TSTB) && bit_ok && in_window &&
                        ((|(cur_rdata & bit_mask)) == IO_WDATA[0]);
        end
    end

    // ------------------------------------------------------------
    // vector placement
    // ------------------------------------------------------------
    logic vsel;
    assign vsel = mcu_control_register[iosv_pkg::BIT_VSEL];
    assign RESET_VECTOR = BOOT_RESET_FUSE ? BOOT_START
                                          : iosv_pkg::APP_RESET_VEC;
    assign VECTOR_BASE  = vsel ? (BOOT_START + iosv_pkg::VEC_SPACING)
                               : iosv_pkg::VEC_SPACING;
    assign JTAG_PORT_DISABLE     = mcu_control_register[iosv_pkg::BIT_JTD];
    assign GLOBAL_PULLUP_DISABLE = mcu_control_register[iosv_pkg::BIT_PUD];

    // ------------------------------------------------------------
    // eeprom timing
    // ------------------------------------------------------------
    iosv_ee_timer #(
        .WRITE_CYC (WRITE_CYC)
    ) u_ee (
        .clk    (SYS_CLK),
        .rst_b  (RST_B),
        .rd_req (EE_READ),
        .wr_req (EE_WRITE),
        .stall  (CPU_STALL),
        .busy   (EE_WRITE_BUSY)
    );

    // ------------------------------------------------------------
    // power-down clock hold
    // ------------------------------------------------------------
    logic pd_hold;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            pd_hold <= 1'b0;
        end else if (SLEEP_POWERDOWN && EE_WRITE_BUSY) begin
            pd_hold <= 1'b1;
        end else if (!SLEEP_POWERDOWN) begin
            pd_hold <= 1'b0;
        end
    end
    assign CLOCK_KEEP = EE_WRITE_BUSY || pd_hold || !SLEEP_POWERDOWN;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_vce_window;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (mcu_wr && merged[iosv_pkg::BIT_VCE]) ##1 (!mcu_wr) [*4] |-> vce_open ##1 !vce_open;
    endproperty
    a_vce_window: assert property (p_vce_window) else $error("vce window");
    property p_vsel_hold;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (!sel_written) |=> $stable(vsel);
    endproperty
    a_vsel_hold: assert property (p_vsel_hold) else $error("vsel changed");
    property p_irq_block;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (mcu_wr && merged[iosv_pkg::BIT_VCE]) |-> IRQ_BLOCK ##1 IRQ_BLOCK;
    endproperty
    a_irq_block: assert property (p_irq_block) else $error("irq not blocked");
    property p_reserved;
        @(posedge SYS_CLK) disable iff (!RST_B)
        mcu_wr |=> (mcu_read[3:2] == 2'b00);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");
    property p_vec_base;
        @(posedge SYS_CLK) disable iff (!RST_B)
        vsel |-> (VECTOR_BASE == BOOT_START + 16'h0002);
    endproperty
    a_vec_base: assert property (p_vec_base) else $error("vector base wrong");
    property p_reset_vec;
        @(posedge SYS_CLK) disable iff (!RST_B)
        !BOOT_RESET_FUSE |-> (RESET_VECTOR == 16'h0000);
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");
    property p_keep;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (EE_WRITE_BUSY && SLEEP_POWERDOWN) |-> CLOCK_KEEP;
    endproperty
    a_keep: assert property (p_keep) else $error("clock dropped");
    property p_map;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (IO_DATA_SPACE && IO_ADDR == 8'h55 && op == iosv_pkg::IOSV_OP_WRITE && !CPU_STALL)
        |=> $past(IO_WDATA[7]) == JTAG_PORT_DISABLE;
    endproperty
    a_map: assert property (p_map) else $error("data space map");
    property p_keep_after;
        @(posedge SYS_CLK) disable iff (!RST_B)
        ($fell(EE_WRITE_BUSY) && SLEEP_POWERDOWN && $past(SLEEP_POWERDOWN)) |-> CLOCK_KEEP;
    endproperty
    a_keep_after: assert property (p_keep_after) else $error("clock dropped after write");
    property p_bit_range;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (bit_op && (IO_DATA_SPACE || io_addr > iosv_pkg::IO_BIT_LIMIT)) |-> !PERIPH_WR && !PERIPH_RD;
    endproperty
    a_bit_range: assert property (p_bit_range) else $error("bit op out of range");
    property p_set_mask;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (op == iosv_pkg::IOSV_OP_SETB && PERIPH_WR) |->
            (PERIPH_WMASK == (8'h01 << IO_BIT)) && ((PERIPH_WDATA & PERIPH_WMASK) == PERIPH_WMASK);
    endproperty
    a_set_mask: assert property (p_set_mask) else $error("set bit mask wrong");
    property p_window;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (!IO_DATA_SPACE && IO_ADDR > iosv_pkg::IO_WINDOW_TOP && op != iosv_pkg::IOSV_OP_NONE)
        |-> !PERIPH_RD && !PERIPH_WR;
    endproperty
    a_window: assert property (p_window) else $error("access outside io window");
    property p_ds_map;
        @(posedge SYS_CLK) disable iff (!RST_B)
        (IO_DATA_SPACE && PERIPH_WR) |-> (PERIPH_ADDR == 6'(IO_ADDR - iosv_pkg::IO_DATA_OFFSET));
    endproperty
    a_ds_map: assert property (p_ds_map) else $error("data space offset wrong");
    property p_stall_gate;
        @(posedge SYS_CLK) disable iff (!RST_B)
        CPU_STALL |-> !PERIPH_RD && !PERIPH_WR && !mcu_wr;
    endproperty
    a_stall_gate: assert property (p_stall_gate) else $error("access during stall");
    property p_tail;
        @(posedge SYS_CLK) disable iff (!RST_B)
        sel_written |=> IRQ_BLOCK;
    endproperty
    a_tail: assert property (p_tail) else $error("irq block dropped early");
    c_vsel: cover property (@(posedge SYS_CLK) sel_written);
    c_timeout: cover property (@(posedge SYS_CLK) vce_open ##4 !vce_open);
    c_skip: cover property (@(posedge SYS_CLK) IO_SKIP);
endmodule

//--- bench/iosv_cpu_model.sv
// cpu side model: issues one io access at a time and waits out stalls
`timescale 1ns/100ps
module iosv_cpu_model (
    input  wire logic       clk,
    input  wire logic       stall,
    input  wire logic [7:0] rdata,
    input  wire logic       hit,
    input  wire logic       skip,
    input  wire logic       p_wr,
    input  wire logic [5:0] p_addr,
    input  wire logic [7:0] p_wmask,
    output logic [2:0]      op,
    output logic            ds,
    output logic [7:0]      addr,
    output logic [2:0]      bsel,
    output logic [7:0]      wdata
);
    initial begin
        op = 3'h0;
        ds = 1'b0;
        addr = 8'hFF;
        bsel = 3'h0;
        wdata = 8'hFF;
    end
    // ------------------------------------------------------------
    // one access: held until taken, then released at the next fall
    // ------------------------------------------------------------
    task automatic access(input logic [2:0] o, input logic d, input logic [7:0] a,
                          input logic [2:0] b, input logic [7:0] w,
                          output logic wr, output logic [5:0] pa, output logic [7:0] wm,
                          output logic [7:0] rd, output logic ht, output logic sk);
        @(negedge clk);
        op = o;
        ds = d;
        addr = a;
        bsel = b;
        wdata = w;
        while (stall) @(negedge clk); // no access while the core is halted
        #1;
        wr = p_wr;
        pa = p_addr;
        wm = p_wmask;
        @(negedge clk);
        rd = rdata;
        ht = hit;
        sk = skip;
        op = 3'h0;
        addr = ~a;
        wdata = ~w;
    endtask
endmodule

//--- bench/test_iosv_top.sv
// testbench: io mapping, eeprom stalls and vector control
`timescale 1ns/100ps
module test_iosv_top;
    localparam int WCYC = 20;
    localparam logic [15:0] BOOT = iosv_pkg::BOOT_START_DEF;
    logic clk = 1'b0, rst_b = 1'b0, ee_rd = 1'b0, ee_wr = 1'b0, pd = 1'b0, fuse = 1'b0;
    logic bso = 1'b0, bsoe = 1'b0, idone = 1'b0;
    logic [7:0] prdata = 8'h00;
    logic [2:0] op, bsel;
    logic ds, hit, skip, p_rd, p_wr, stall, busy, keep, irq_blk, jtd_o, pud_o;
    logic [7:0] addr, wdata, rdata, p_wdata, p_wmask;
    logic [5:0] p_addr;
    logic [15:0] rst_vec, vec_base;
    logic wr, ht, sk;
    logic [5:0] pa;
    logic [7:0] wm, rd;
    int errors = 0, n_tests = 0, cycles = 0, seed = 81, vsel = 0;
    logic last_rd;
    logic [7:0] last_wdata;
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (p_rd || p_wr) begin
            last_rd <= p_rd;
            last_wdata <= p_wdata;
        end
    end
    iosv_top #(.WRITE_CYC(WCYC)) iosv_top_inst (.SYS_CLK(clk), .RST_B(rst_b), .IO_OP(op),
        .IO_DATA_SPACE(ds), .IO_ADDR(addr), .IO_BIT(bsel), .IO_WDATA(wdata), .IO_RDATA(rdata),
        .IO_HIT(hit), .IO_SKIP(skip), .PERIPH_ADDR(p_addr), .PERIPH_RD(p_rd), .PERIPH_WR(p_wr),
        .PERIPH_WDATA(p_wdata), .PERIPH_WMASK(p_wmask), .PERIPH_RDATA(prdata), .EE_READ(ee_rd),
        .EE_WRITE(ee_wr), .CPU_STALL(stall), .EE_WRITE_BUSY(busy), .SLEEP_POWERDOWN(pd),
        .CLOCK_KEEP(keep), .BOOT_RESET_FUSE(fuse), .BROWNOUT_SLEEP_OFF(bso),
        .BROWNOUT_SLEEP_OFF_ENABLE(bsoe), .INSTR_DONE(idone), .RESET_VECTOR(rst_vec),
        .VECTOR_BASE(vec_base), .IRQ_BLOCK(irq_blk), .JTAG_PORT_DISABLE(jtd_o),
        .GLOBAL_PULLUP_DISABLE(pud_o));
    iosv_cpu_model iosv_cpu_model_inst (.clk(clk), .stall(stall), .rdata(rdata), .hit(hit),
        .skip(skip), .p_wr(p_wr), .p_addr(p_addr), .p_wmask(p_wmask), .op(op), .ds(ds),
        .addr(addr), .bsel(bsel), .wdata(wdata));
    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish;
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic mcu(input logic [2:0] o, input logic d, input logic [7:0] v);
        iosv_cpu_model_inst.access(o, d, d ? iosv_pkg::DS_MCU_CONTROL :
            {2'b00, iosv_pkg::IO_MCU_CONTROL}, 3'h0, v, wr, pa, wm, rd, ht, sk);
    endtask
    task automatic check_vec;
        for (int f = 0; f < 2; f++) begin
            @(negedge clk);
            fuse = f[0];
            #1;
            check(rst_vec, f ? BOOT : iosv_pkg::APP_RESET_VEC);
            check(vec_base, (vsel ? BOOT : 16'h0000) + iosv_pkg::VEC_SPACING);
        end
    endtask
    task automatic ee_pulse(input logic w, input int exp_stall);
        int n = 0;
        @(negedge clk);
        ee_rd = !w;
        ee_wr = w;
        @(negedge clk);
        ee_rd = 1'b0;
        ee_wr = 1'b0;
        while (stall && n < 20) begin
            n++;
            @(negedge clk);
        end
        check(n, exp_stall);
    endtask
    task automatic wait_busy_low;
        int n = 0;
        while (busy && n < 100) begin
            n++;
            @(negedge clk);
        end
        check(n <= WCYC && busy === 1'b0, 1'b1); // write completes by itself
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] a, d;
        logic [2:0] b;
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        mcu(iosv_pkg::IOSV_OP_READ, 1'b0, 8'h00);
        check(rd, iosv_pkg::MCU_RESET);
        check_vec;
        bso = 1'b1;
        mcu(iosv_pkg::IOSV_OP_WRITE, 1'b1, 8'hFE);
        mcu(iosv_pkg::IOSV_OP_READ, 1'b1, 8'h00);
        check(rd, 8'hD0);
        check({jtd_o, pud_o}, 2'b11);
        mcu(iosv_pkg::IOSV_OP_WRITE, 1'b0, 8'h91);
        check(irq_blk, 1'b1);
        mcu(iosv_pkg::IOSV_OP_WRITE, 1'b0, 8'h92);
        vsel = 1;
        check(irq_blk, 1'b1);
        idone = 1'b1;
        @(negedge clk);
        idone = 1'b0;
        @(negedge clk);
        check(irq_blk, 1'b0);
        check_vec;
        mcu(iosv_pkg::IOSV_OP_WRITE, 1'b1, 8'h91);
        repeat (6) @(negedge clk);
        check(irq_blk, 1'b0);
        mcu(iosv_pkg::IOSV_OP_WRITE, 1'b1, 8'h90);
        mcu(iosv_pkg::IOSV_OP_READ, 1'b0, 8'h00);
        check(rd, 8'hD2); // late select write ignored
        for (int i = 0; i < 8; i++) begin
            a = 8'($random(seed)) & 8'h3F;
            if (a == 8'h35) a = 8'h34;
            d = 8'($random(seed));
            b = 3'($random(seed));
            prdata = 8'($random(seed));
            iosv_cpu_model_inst.access(iosv_pkg::IOSV_OP_WRITE, i[0],
                i[0] ? a + iosv_pkg::IO_DATA_OFFSET : a, 3'h0, d, wr, pa, wm, rd, ht, sk);
            check({wr, ht, pa}, {2'b11, a[5:0]});
            check(last_wdata, d);
            iosv_cpu_model_inst.access(iosv_pkg::IOSV_OP_READ, i[1],
                i[1] ? a + iosv_pkg::IO_DATA_OFFSET : a, 3'h0, d, wr, pa, wm, rd, ht, sk);
            check(rd, prdata);
            check(last_rd, 1'b1);
            iosv_cpu_model_inst.access(i[0] ? iosv_pkg::IOSV_OP_SETB : iosv_pkg::IOSV_OP_CLRB,
                1'b0, a & 8'h1F, b, d, wr, pa, wm, rd, ht, sk);
            check({wr, wm}, {1'b1, 8'h01 << b});
            check(last_wdata[b], i[0]);
            iosv_cpu_model_inst.access(iosv_pkg::IOSV_OP_TSTB, 1'b0, a & 8'h1F, b, d,
                wr, pa, wm, rd, ht, sk);
            check(sk, prdata[b] == d[0]);
            iosv_cpu_model_inst.access(iosv_pkg::IOSV_OP_SETB, 1'b0, (a & 8'h1F) | 8'h20, b, d,
                wr, pa, wm, rd, ht, sk);
            check(wr, 1'b0);
        end
        iosv_cpu_model_inst.access(iosv_pkg::IOSV_OP_WRITE, 1'b0, a | 8'h40, 3'h0, d,
            wr, pa, wm, rd, ht, sk);
        check({wr, ht}, 2'b00);
        ee_pulse(1'b0, 4);
        ee_pulse(1'b1, 2);
        check(busy, 1'b1); // cpu resumes while write runs
        pd = 1'b1;
        #1;
        check(keep, 1'b1);
        wait_busy_low;
        #1;
        check(keep, 1'b1); // clock stays held after the write
        @(negedge clk);
        pd = 1'b0;
        @(negedge clk);
        pd = 1'b1;
        #1;
        check(keep, 1'b0); // idle power-down releases the clock
        @(negedge clk);
        pd = 1'b0;
        ee_pulse(1'b1, 2);
        ee_pulse(1'b1, 0);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        check(busy, 1'b1);
        wait_busy_low;
        tally_and_finish;
    end
endmodule
